// ==== fasr_pkg.sv ====
package fasr_pkg;

	// Register index width; byte address is four times the index
	localparam int unsigned FASR_IDX_W = 14;
	localparam int unsigned FASR_DAT_W = 32;
	localparam int unsigned FASR_SEL_W = 4;

	// Register indices
	localparam logic [13:0] FASR_IDX_SEQ_STATE   = 14'h06b8;
	localparam logic [13:0] FASR_IDX_INIT_ANGLE  = 14'h06fc;
	localparam logic [13:0] FASR_IDX_BEMF_D      = 14'h0742;
	localparam logic [13:0] FASR_IDX_BEMF_Q      = 14'h0744;
	localparam logic [13:0] FASR_IDX_SPEED       = 14'h0752;
	localparam logic [13:0] FASR_IDX_ROTOR_ANGLE = 14'h0756;
	localparam logic [13:0] FASR_IDX_INT_STATUS  = 14'h07f0;
	localparam logic [13:0] FASR_IDX_INT_MASK    = 14'h07f1;
	localparam logic [13:0] FASR_IDX_UPD_CNT_LO  = 14'h07f2;
	localparam logic [13:0] FASR_IDX_UPD_CNT_HI  = 14'h07f3;

	// Channel numbering of the stored values
	localparam int unsigned FASR_NUM_CH         = 6;
	localparam int unsigned FASR_CH_SEQ_STATE   = 0;
	localparam int unsigned FASR_CH_INIT_ANGLE  = 1;
	localparam int unsigned FASR_CH_BEMF_D      = 2;
	localparam int unsigned FASR_CH_BEMF_Q      = 3;
	localparam int unsigned FASR_CH_SPEED       = 4;
	localparam int unsigned FASR_CH_ROTOR_ANGLE = 5;

	// Field layout
	localparam int unsigned FASR_STATE_W    = 16;
	localparam int unsigned FASR_FRAC_BITS  = 27;
	localparam int unsigned FASR_CNT_W      = 8;
	localparam int unsigned FASR_EV_W       = 8;
	localparam int unsigned FASR_EV_SEQ_DONE  = 6;
	localparam int unsigned FASR_EV_SEQ_FAULT = 7;

	// Reset values
	localparam logic [31:0] FASR_WORD_RST = 32'h0000_0000;
	localparam logic [7:0]  FASR_EV_RST   = 8'h00;
	localparam logic [7:0]  FASR_CNT_RST  = 8'h00;

	// Initial position sequence states
	typedef enum logic [15:0] {
		FASR_SEQ_INIT          = 16'h0000,
		FASR_SEQ_VECTOR_CONFIG = 16'h0001,
		FASR_SEQ_RUN           = 16'h0002,
		FASR_SEQ_SLOW_RISE_CLK = 16'h0003,
		FASR_SEQ_SLOW_FALL_CLK = 16'h0004,
		FASR_SEQ_WAIT_DECAY    = 16'h0005,
		FASR_SEQ_GET_TIMES     = 16'h0006,
		FASR_SEQ_SET_NEXT_VEC  = 16'h0007,
		FASR_SEQ_CALC_SECTOR   = 16'h0008,
		FASR_SEQ_CALC_POSITION = 16'h0009,
		FASR_SEQ_CALC_ANGLE    = 16'h000a,
		FASR_SEQ_COMPLETE      = 16'h000b,
		FASR_SEQ_FAULT         = 16'h000c
	} fasr_seq_state_t;

endpackage

// ==== fasr_status_regs.sv ====
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module fasr_status_regs
	import fasr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [15:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq,
	input  wire logic        seq_state_vld,
	input  wire logic [15:0] seq_state_dat,
	input  wire logic        init_angle_vld,
	input  wire logic [31:0] init_angle_dat,
	input  wire logic        bemf_d_vld,
	input  wire logic [31:0] bemf_d_dat,
	input  wire logic        bemf_q_vld,
	input  wire logic [31:0] bemf_q_dat,
	input  wire logic        speed_vld,
	input  wire logic [31:0] speed_dat,
	input  wire logic        rotor_angle_vld,
	input  wire logic [31:0] rotor_angle_dat
);

	// Update strobes and words from the control algorithm, gathered per channel
	logic [FASR_NUM_CH-1:0] upd_vld;
	logic [31:0]            upd_dat [FASR_NUM_CH];

	assign upd_vld[FASR_CH_SEQ_STATE]   = seq_state_vld;
	assign upd_vld[FASR_CH_INIT_ANGLE]  = init_angle_vld;
	assign upd_vld[FASR_CH_BEMF_D]      = bemf_d_vld;
	assign upd_vld[FASR_CH_BEMF_Q]      = bemf_q_vld;
	assign upd_vld[FASR_CH_SPEED]       = speed_vld;
	assign upd_vld[FASR_CH_ROTOR_ANGLE] = rotor_angle_vld;

	// Upper half of the state word is reserved and stays zero
	assign upd_dat[FASR_CH_SEQ_STATE]   = {16'h0000, seq_state_dat};
	assign upd_dat[FASR_CH_INIT_ANGLE]  = init_angle_dat;
	assign upd_dat[FASR_CH_BEMF_D]      = bemf_d_dat;
	assign upd_dat[FASR_CH_BEMF_Q]      = bemf_q_dat;
	assign upd_dat[FASR_CH_SPEED]       = speed_dat;
	assign upd_dat[FASR_CH_ROTOR_ANGLE] = rotor_angle_dat;

	// Stored values and per-channel update counters
	logic [31:0]           val_reg [FASR_NUM_CH];
	logic [FASR_CNT_W-1:0] cnt_reg [FASR_NUM_CH];

	// One storage slot per channel; only the algorithm strobe loads it
	genvar ch;
	generate
		for (ch = 0; ch < FASR_NUM_CH; ch++) begin : g_ch
			always_ff @(posedge clock) begin
				if (!nrst) begin
					val_reg[ch] <= FASR_WORD_RST;
				end else if (upd_vld[ch]) begin
					val_reg[ch] <= upd_dat[ch];
				end
			end

			// Counter wraps, so software sees activity by difference
			always_ff @(posedge clock) begin
				if (!nrst) begin
					cnt_reg[ch] <= FASR_CNT_RST;
				end else if (upd_vld[ch]) begin
					cnt_reg[ch] <= cnt_reg[ch] + 8'h01;
				end
			end
		end
	endgenerate

	// Sequence state as stored, for completion and fault detection
	logic [15:0] seq_now;
	logic        seq_enter_done;
	logic        seq_enter_fault;

	assign seq_now         = val_reg[FASR_CH_SEQ_STATE][15:0];
	// Done and fault events fire only on entry, so repeated state reports do not re-raise them
	assign seq_enter_done  = seq_state_vld
		&& (seq_state_dat == FASR_SEQ_COMPLETE)
		&& (seq_now != FASR_SEQ_COMPLETE);
	assign seq_enter_fault = seq_state_vld
		&& (seq_state_dat == FASR_SEQ_FAULT)
		&& (seq_now != FASR_SEQ_FAULT);

	// Bus request decode; the slave answers one cycle after the request
	logic        req;
	logic        take;
	logic        wr_take;
	logic [13:0] idx;

	assign req     = wb_cyc_i && wb_stb_i;
	assign take    = req && !wb_ack_o;
	assign wr_take = take && wb_we_i;
	assign idx     = wb_adr_i[15:2];

	// Address hits
	logic hit_seq;
	logic hit_init_angle;
	logic hit_bemf_d;
	logic hit_bemf_q;
	logic hit_speed;
	logic hit_rotor_angle;
	logic hit_status;
	logic hit_mask;
	logic hit_cnt_lo;
	logic hit_cnt_hi;

	assign hit_seq         = (idx == FASR_IDX_SEQ_STATE);
	assign hit_init_angle  = (idx == FASR_IDX_INIT_ANGLE);
	assign hit_bemf_d      = (idx == FASR_IDX_BEMF_D);
	assign hit_bemf_q      = (idx == FASR_IDX_BEMF_Q);
	assign hit_speed       = (idx == FASR_IDX_SPEED);
	assign hit_rotor_angle = (idx == FASR_IDX_ROTOR_ANGLE);
	assign hit_status      = (idx == FASR_IDX_INT_STATUS);
	assign hit_mask        = (idx == FASR_IDX_INT_MASK);
	assign hit_cnt_lo      = (idx == FASR_IDX_UPD_CNT_LO);
	assign hit_cnt_hi      = (idx == FASR_IDX_UPD_CNT_HI);

	// Interrupt status and mask; the low byte lane carries both
	logic [FASR_EV_W-1:0] status_reg;
	logic [FASR_EV_W-1:0] status_next;
	logic [FASR_EV_W-1:0] mask_reg;
	logic [FASR_EV_W-1:0] mask_next;
	logic [FASR_EV_W-1:0] ev_set;
	logic [FASR_EV_W-1:0] ev_clr;
	logic                 mask_wr;

	// Only status and mask accept writes; value addresses drop them
	assign ev_set      = {seq_enter_fault, seq_enter_done, upd_vld};
	assign ev_clr      = (wr_take && hit_status && wb_sel_i[0]) ? wb_dat_i[7:0] : FASR_EV_RST;
	assign status_next = (status_reg & ~ev_clr) | ev_set; // Set wins over clear
	assign mask_wr     = wr_take && hit_mask && wb_sel_i[0];
	assign mask_next   = mask_wr ? wb_dat_i[7:0] : mask_reg;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			status_reg <= FASR_EV_RST;
			mask_reg   <= FASR_EV_RST;
		end else begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
		end
	end

	// Level interrupt while any unmasked event is pending
	assign irq = |(status_reg & mask_reg);

	// Read selection; unmapped indices read zero
	logic [31:0] rd_mux;

	assign rd_mux =
		hit_seq         ? val_reg[FASR_CH_SEQ_STATE]   :
		hit_init_angle  ? val_reg[FASR_CH_INIT_ANGLE]  :
		hit_bemf_d      ? val_reg[FASR_CH_BEMF_D]      :
		hit_bemf_q      ? val_reg[FASR_CH_BEMF_Q]      :
		hit_speed       ? val_reg[FASR_CH_SPEED]       :
		hit_rotor_angle ? val_reg[FASR_CH_ROTOR_ANGLE] :
		hit_status      ? {24'h000000, status_reg}     :
		hit_mask        ? {24'h000000, mask_reg}       :
		hit_cnt_lo      ? {cnt_reg[3], cnt_reg[2], cnt_reg[1], cnt_reg[0]} :
		hit_cnt_hi      ? {16'h0000, cnt_reg[5], cnt_reg[4]} :
		FASR_WORD_RST;

	// Acknowledge and read data, both registered
	always_ff @(posedge clock) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= FASR_WORD_RST;
		end else begin
			wb_ack_o <= take;
			if (take && !wb_we_i) begin
				wb_dat_o <= rd_mux;
			end
		end
	end

endmodule

// ==== fasr_status_regs_sva.sv ====
`timescale 1ns/1ps
module fasr_status_regs_sva
	import fasr_pkg::*;
(
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        irq,
	input wire logic        speed_vld,
	input wire logic [31:0] speed_dat
);
	logic [31:0] spd_q;
	// Read request waiting for its answer
	wire rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
	// Shadow of the latest speed update
	always_ff @(posedge clock) begin
		if (!nrst)
			spd_q <= '0;
		else if (speed_vld)
			spd_q <= speed_dat;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	a_reset_clears: assert property (disable iff (1'b0) !nrst |=> !wb_ack_o && !irq
		&& wb_dat_o == 32'h0) else $error("outputs not cleared by reset");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_dat_holds: assert property ($changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i))
		else $error("read data moved outside a read");
	a_speed_read: assert property (rd && wb_adr_i[15:2] == FASR_IDX_SPEED
		|=> wb_dat_o == $past(spd_q)) else $error("speed read wrong");
	a_state_upper: assert property (rd && wb_adr_i[15:2] == FASR_IDX_SEQ_STATE
		|=> wb_dat_o[31:16] == 16'h0) else $error("state upper half not zero");
	a_unmapped_zero: assert property (rd && wb_adr_i[15:2] == 14'h0000
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	c_speed_read: cover property (rd && wb_adr_i[15:2] == FASR_IDX_SPEED);
	c_irq_rise: cover property ($rose(irq));
	c_write_ack: cover property (wb_ack_o && wb_we_i);
endmodule
bind fasr_status_regs fasr_status_regs_sva chk (
	.clock     (clock),
	.nrst      (nrst),
	.wb_cyc_i  (wb_cyc_i),
	.wb_stb_i  (wb_stb_i),
	.wb_we_i   (wb_we_i),
	.wb_adr_i  (wb_adr_i),
	.wb_dat_o  (wb_dat_o),
	.wb_ack_o  (wb_ack_o),
	.irq       (irq),
	.speed_vld (speed_vld),
	.speed_dat (speed_dat)
);

// ==== fasr_status_regs_bench.sv ====
`timescale 1ns/1ps
module fasr_status_regs_bench
	import fasr_pkg::*;
;
	logic        clock, nrst, cyc, stb, we, ack, irq;
	logic [15:0] adr;
	logic [31:0] wdat, rdo, q;
	logic [3:0]  sel;
	logic [5:0]  vld;
	logic [31:0] vdat [6];
	logic [13:0] idx [6] = '{FASR_IDX_SEQ_STATE, FASR_IDX_INIT_ANGLE, FASR_IDX_BEMF_D,
		FASR_IDX_BEMF_Q, FASR_IDX_SPEED, FASR_IDX_ROTOR_ANGLE};
	int          n_mismatch, n_checks;
	fasr_status_regs dut (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdo),
		.wb_ack_o(ack), .irq(irq), .seq_state_vld(vld[0]), .seq_state_dat(vdat[0][15:0]),
		.init_angle_vld(vld[1]), .init_angle_dat(vdat[1]), .bemf_d_vld(vld[2]),
		.bemf_d_dat(vdat[2]), .bemf_q_vld(vld[3]), .bemf_q_dat(vdat[3]),
		.speed_vld(vld[4]), .speed_dat(vdat[4]), .rotor_angle_vld(vld[5]),
		.rotor_angle_dat(vdat[5]));
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	// One classic Wishbone cycle, waits for ack under a bound
	task bus(input logic w, input logic [13:0] i, input logic [31:0] d);
		int n;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= d;
		for (n = 0; n < 20 && ack !== 1'b1; n++)
			@(posedge clock);
		if (ack !== 1'b1) begin
			n_mismatch++;
			close_out();
		end
		q = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task pulse(input int c, input logic [31:0] d);
		@(posedge clock);
		vld[c] <= 1'b1;
		vdat[c] <= d;
		@(posedge clock);
		vld[c] <= 1'b0;
	endtask
	function automatic logic [31:0] pat(input int i);
		return 32'h8000_0001 ^ (32'h0f0f_0f0f << i);
	endfunction
	task t_reset;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, idx[i], 32'h0);
			chk("reset value", 32'h0, q);
		end
	endtask
	task t_codes;
		for (int k = 0; k < 13; k++) begin
			pulse(0, k);
			bus(1'b0, FASR_IDX_SEQ_STATE, 32'h0);
			chk("state", k, q);
		end
	endtask
	task t_values;
		for (int i = 1; i < 6; i++)
			pulse(i, pat(i));
		for (int i = 1; i < 6; i++) begin
			bus(1'b1, idx[i], ~pat(i));
			bus(1'b0, idx[i], 32'h0);
			chk("value", pat(i), q);
		end
		bus(1'b0, 14'h0000, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'b0, FASR_IDX_UPD_CNT_LO, 32'h0);
		chk("counts", 32'h0101_010d, q);
		bus(1'b0, FASR_IDX_UPD_CNT_HI, 32'h0);
		chk("counts hi", 32'h0000_0101, q);
	endtask
	task t_irq;
		bus(1'b0, FASR_IDX_INT_STATUS, 32'h0);
		chk("status", 32'hff, q);
		chk("irq masked", 32'h0, irq);
		// Mask write on a disabled low byte lane must be dropped
		sel <= 4'he;
		bus(1'b1, FASR_IDX_INT_MASK, 32'h10);
		sel <= 4'hf;
		chk("irq lane off", 32'h0, irq);
		bus(1'b1, FASR_IDX_INT_MASK, 32'h10);
		chk("irq on", 32'h1, irq);
		bus(1'b0, FASR_IDX_INT_MASK, 32'h0);
		chk("mask", 32'h10, q);
		bus(1'b1, FASR_IDX_INT_STATUS, 32'hef);
		chk("irq kept", 32'h1, irq);
		bus(1'b1, FASR_IDX_INT_STATUS, 32'h10);
		chk("irq cleared", 32'h0, irq);
		pulse(4, 32'h0000_0abc);
		bus(1'b0, FASR_IDX_SPEED, 32'h0);
		chk("speed", 32'h0000_0abc, q);
		chk("irq again", 32'h1, irq);
	endtask
	// Reset in mid-run clears every stored value and the interrupt
	task t_rerun;
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		chk("irq after reset", 32'h0, irq);
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, idx[i], 32'h0);
			chk("value after reset", 32'h0, q);
		end
		bus(1'b0, FASR_IDX_INT_STATUS, 32'h0);
		chk("status after reset", 32'h0, q);
	endtask
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial begin
		{nrst, cyc, stb, we, adr, wdat, vld} = '0;
		vdat = '{default: 32'h0};
		sel = 4'hf;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_codes();
		t_values();
		t_irq();
		t_rerun();
		close_out();
	end
endmodule
